/* File: verilog/owf_formatter.sv */
/*
 * Output word formatter: one format register on classic Wishbone and a
 * registered 20-bit output word built from the conversion result.
 * Assumes conv_valid_i pulses with each new result, synchronous to clk_i.
 */
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "owf_map.svh"
module owf_formatter #(
    parameter int RESULT_W = 18
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic [RESULT_W-1:0] conv_data_i,
    input  wire logic                conv_valid_i,
    output logic      [RESULT_W+1:0] word_o,
    output logic                     word_valid_o
);
    logic [5:0]          format_q;
    logic [RESULT_W-1:0] field_d;
    logic                full_par;
    logic                span_par;
    logic                req;
    logic [31:0]         rdata_d;
    logic [RESULT_W+1:0] word_d;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // ======================================================================
    // wishbone slave: one-cycle ack, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (wb_adr_i == `OWF_ADDR_FORMAT) begin
            rdata_d = {26'h0, format_q};
        end else if (wb_adr_i == `OWF_ADDR_STATUS) begin
            rdata_d = {12'h0, word_o};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= rdata_d;
        end
    end

    // ======================================================================
    // format register; reserved bits 7-6 are not stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            format_q <= 6'(`OWF_FORMAT_RESET);
        end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == `OWF_ADDR_FORMAT) begin
            format_q <= wb_dat_i[5:0] & 6'(`OWF_FORMAT_WMASK);
        end
    end

    // ======================================================================
    // upper field selection
    always_comb begin
        case (owf_pkg::owf_patn_t'(format_q[`OWF_PATN_HI:`OWF_PATN_LO]))
            owf_pkg::OWF_PATN_ZERO:       field_d = `OWF_PATN_ZEROS;
            owf_pkg::OWF_PATN_ONE:        field_d = `OWF_PATN_ONES;
            owf_pkg::OWF_PATN_ALT_SINGLE: field_d = `OWF_PATN_ALT1;
            owf_pkg::OWF_PATN_ALT_PAIR:   field_d = `OWF_PATN_ALT2;
            default:                      field_d = conv_data_i;
        endcase
    end

    // parity taken from the field actually sent, pattern or result
    owf_parity #(
        .FIELD_W (RESULT_W)
    ) u_parity (
        .field_i    (field_d),
        .span_i     (format_q[`OWF_SPAN_HI:`OWF_SPAN_LO]),
        .full_par_o (full_par),
        .span_par_o (span_par)
    );

    always_comb begin
        word_d = {field_d, 2'b00};
        if (format_q[`OWF_PARITY_APPEND_ENABLE_BIT]) begin
            word_d[1:0] = {full_par, span_par};
        end
    end

    // ======================================================================
    // output word register, loaded with each new result
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_o <= '0;
        end else if (conv_valid_i) begin
            word_o <= word_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_valid_o <= 1'b0;
        end else begin
            word_valid_o <= conv_valid_i;
        end
    end

    // ======================================================================
    // assertions
    property p_reserved_zero;
        @(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && $past(!wb_we_i) && $past(wb_adr_i) == `OWF_ADDR_FORMAT)
            |-> wb_dat_o[7:6] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

    property p_no_parity;
        @(posedge clk_i) disable iff (rst_i)
        (conv_valid_i && !format_q[3]) |=> word_o[1:0] == 2'b00;
    endproperty
    a_no_parity: assert property (p_no_parity) else $error("parity bits set while off");

    property p_full_parity;
        @(posedge clk_i) disable iff (rst_i)
        (conv_valid_i && format_q[3]) |=> ^word_o[RESULT_W+1:1] == 1'b0;
    endproperty
    a_full_parity: assert property (p_full_parity) else $error("full parity wrong");

    property p_span_parity;
        @(posedge clk_i) disable iff (rst_i)
        (conv_valid_i && format_q[3] && format_q[5:4] == 2'b00)
            |=> (^word_o[RESULT_W+1 -: 4]) == word_o[0];
    endproperty
    a_span_parity: assert property (p_span_parity) else $error("span-4 parity wrong");

    property p_conv_pass;
        @(posedge clk_i) disable iff (rst_i)
        (conv_valid_i && !format_q[2]) |=> word_o[RESULT_W+1:2] == $past(conv_data_i);
    endproperty
    a_conv_pass: assert property (p_conv_pass) else $error("result not passed");

    property p_ones;
        @(posedge clk_i) disable iff (rst_i)
        (conv_valid_i && format_q[2:0] == 3'h5) |=> &word_o[RESULT_W+1:2];
    endproperty
    a_ones: assert property (p_ones) else $error("all-ones pattern wrong");

    property p_alt;
        @(posedge clk_i) disable iff (rst_i)
        (conv_valid_i && format_q[2:0] == 3'h6) |=> word_o[RESULT_W+1:2] == 18'h15555;
    endproperty
    a_alt: assert property (p_alt) else $error("alternating pattern wrong");

    // no $past here: its value before the first edge is undefined
    property p_reset_fmt;
        @(posedge clk_i) rst_i |=> format_q == 6'h00;
    endproperty
    a_reset_fmt: assert property (p_reset_fmt) else $error("format not cleared by reset");

    property p_span_8;
        @(posedge clk_i) disable iff (rst_i)
        (conv_valid_i && format_q[3] && format_q[5:4] == 2'b01)
            |=> (^word_o[RESULT_W+1 -: 8]) == word_o[0];
    endproperty
    a_span_8: assert property (p_span_8) else $error("span-8 parity wrong");

    property p_span_12;
        @(posedge clk_i) disable iff (rst_i)
        (conv_valid_i && format_q[3] && format_q[5:4] == 2'b10)
            |=> (^word_o[RESULT_W+1 -: 12]) == word_o[0];
    endproperty
    a_span_12: assert property (p_span_12) else $error("span-12 parity wrong");

    property p_span_16;
        @(posedge clk_i) disable iff (rst_i)
        (conv_valid_i && format_q[3] && format_q[5:4] == 2'b11)
            |=> (^word_o[RESULT_W+1 -: 16]) == word_o[0];
    endproperty
    a_span_16: assert property (p_span_16) else $error("span-16 parity wrong");

    property p_zeros;
        @(posedge clk_i) disable iff (rst_i)
        (conv_valid_i && format_q[2:0] == 3'h4)
            |=> word_o[RESULT_W+1:2] == `OWF_PATN_ZEROS;
    endproperty
    a_zeros: assert property (p_zeros) else $error("all-zeros pattern wrong");

    property p_alt_pair;
        @(posedge clk_i) disable iff (rst_i)
        (conv_valid_i && format_q[2:0] == 3'h7)
            |=> word_o[RESULT_W+1:2] == `OWF_PATN_ALT2;
    endproperty
    a_alt_pair: assert property (p_alt_pair) else $error("pair pattern wrong");

    property p_valid_follows;
        @(posedge clk_i) disable iff (rst_i)
        conv_valid_i |=> word_valid_o;
    endproperty
    a_valid_follows: assert property (p_valid_follows) else $error("word valid missing");

    property p_valid_idle;
        @(posedge clk_i) disable iff (rst_i)
        !conv_valid_i |=> !word_valid_o;
    endproperty
    a_valid_idle: assert property (p_valid_idle) else $error("word valid without result");

    // the host may read the word late, so it must not drift between results
    property p_word_hold;
        @(posedge clk_i) disable iff (rst_i)
        !conv_valid_i |=> $stable(word_o);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("word changed without result");

    property p_ack_answer;
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("bus request not acknowledged");

    property p_ack_single;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");

    property p_sel_ignored;
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && !wb_sel_i[0])
            |=> $stable(format_q);
    endproperty
    a_sel_ignored: assert property (p_sel_ignored) else $error("unselected write landed");
endmodule

/* File: verilog/owf_map.svh */
/*
 * Constants of the output word formatter: register offset, field positions,
 * reset value and test patterns.
 * Assumes a Wishbone slave with 32-bit data and byte addresses.
 */
// How it works
// - bits 7-6 of the format register read zero, writes ignored.
// - span field 5-4 picks 4, 8, 12 or 16 MSBs for span parity.
// - parity append disabled drives D[1] and D[0] low.
// - parity append enabled puts even parity of D[19:2] into D[1].
// - parity append enabled puts even parity of selected MSB span into D[0].
// - pattern select MSB zero places 18-bit conversion result in D[19:2].
// - pattern 100b drives all zeros, 101b drives all ones.
// - pattern 110b gives 15555h, 111b gives 03333h.
// - output word is 20 bits, governed by the format register.
`ifndef OWF_MAP_SVH
`define OWF_MAP_SVH

// ==========================================================================
// register map
`define OWF_ADDR_FORMAT     8'h1c
`define OWF_ADDR_STATUS     8'h20
`define OWF_FORMAT_RESET    8'h00
`define OWF_FORMAT_WMASK    8'h3f

// ==========================================================================
// field positions
`define OWF_SPAN_HI         5
`define OWF_SPAN_LO         4
`define OWF_PARITY_APPEND_ENABLE_BIT      3
`define OWF_PATN_HI         2
`define OWF_PATN_LO         0

// ==========================================================================
// test patterns for D[19:2]
`define OWF_PATN_ZEROS      18'h00000
`define OWF_PATN_ONES       18'h3ffff
`define OWF_PATN_ALT1       18'h15555
`define OWF_PATN_ALT2       18'h03333

`endif

/* File: verilog/owf_pkg.sv */
/*
 * Types of the output word formatter.
 * Assumes nothing beyond the map header.
 */
package owf_pkg;
    typedef enum logic [2:0] {
        OWF_PATN_CONV0,
        OWF_PATN_CONV1,
        OWF_PATN_CONV2,
        OWF_PATN_CONV3,
        OWF_PATN_ZERO,
        OWF_PATN_ONE,
        OWF_PATN_ALT_SINGLE,
        OWF_PATN_ALT_PAIR
    } owf_patn_t;

    typedef enum logic [1:0] {
        OWF_SPAN_4,
        OWF_SPAN_8,
        OWF_SPAN_12,
        OWF_SPAN_16
    } owf_span_t;
endpackage

/* File: verilog/owf_parity.sv */
/*
 * Even parity generator for the formatted word: full-field and span bits.
 * Assumes an 18-bit upper field and a two-bit span code.
 */
`timescale 1ns/1ps
module owf_parity #(
    parameter int FIELD_W = 18
) (
    input  wire logic [FIELD_W-1:0] field_i,
    input  wire logic [1:0]         span_i,
    output logic                    full_par_o,
    output logic                    span_par_o
);
    logic [FIELD_W-1:0] span_mask;

    always_comb begin
        span_mask = '0;
        // span of 4, 8, 12 or 16 most significant bits
        case (owf_pkg::owf_span_t'(span_i))
            owf_pkg::OWF_SPAN_4:  span_mask[FIELD_W-1 -: 4]  = '1;
            owf_pkg::OWF_SPAN_8:  span_mask[FIELD_W-1 -: 8]  = '1;
            owf_pkg::OWF_SPAN_12: span_mask[FIELD_W-1 -: 12] = '1;
            default:              span_mask[FIELD_W-1 -: 16] = '1;
        endcase
        full_par_o = ^field_i;
        span_par_o = ^(field_i & span_mask);
    end
endmodule

/* File: verif/owf_host_model.sv */
/*
 * Host model: keeps the last formatted word it is handed and counts them all.
 * Assumes word_valid_i is a one-cycle pulse synchronous to clk_i.
 */
`timescale 1ns/1ps
module owf_host_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [19:0] word_i,
    input  wire logic        word_valid_i,
    output logic      [19:0] last_o,
    output logic      [15:0] count_o
);
    // =====================================================
    // capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_o  <= 20'h00000;
            count_o <= 16'h0000;
        end else if (word_valid_i) begin
            last_o  <= word_i;
            count_o <= count_o + 16'h0001;
        end
    end
endmodule

/* File: verif/owf_formatter_bench.sv */
/*
 * Self-checking bench of the output word formatter.
 * Assumes a 4 ns clock and the register map of owf_map.svh.
 */
`timescale 1ns/1ps
`include "owf_map.svh"
module owf_formatter_bench;
    logic        clk, rst, cyc, stb, we, ack, cv, wv;
    logic [7:0]  adr, fmt;
    logic [3:0]  sel, wsel;
    logic [31:0] dat, rdo, rdat;
    logic [17:0] cd;
    logic [19:0] word, hlast;
    logic [15:0] hcount;
    int          bad_count, tests_run;
    // =====================================================
    // design and host
    owf_formatter uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo),
        .wb_ack_o(ack), .conv_data_i(cd), .conv_valid_i(cv), .word_o(word),
        .word_valid_o(wv));
    owf_host_model host (.clk_i(clk), .rst_i(rst), .word_i(word), .word_valid_i(wv),
        .last_o(hlast), .count_o(hcount));
    always #2 clk = ~clk;
    // =====================================================
    // helpers
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    function automatic logic [19:0] expw(input logic [7:0] f, input logic [17:0] d);
        logic [17:0] v;
        logic [17:0] m;
        v = d;
        if (f[2])
            v = f[1] ? (f[0] ? `OWF_PATN_ALT2 : `OWF_PATN_ALT1)
                     : (f[0] ? `OWF_PATN_ONES : `OWF_PATN_ZEROS);
        m = 18'h3ffff << (14 - 4 * f[5:4]);
        return f[3] ? {v, ^v, ^(v & m)} : {v, 2'b00};
    endfunction
    // master waits on ack as long as it takes; only the watchdog ends a stall
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= wsel;
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk("ack wait", 32'h1, n);
        rdat = rdo;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
    endtask
    task conv(input logic [7:0] f, input logic [17:0] d);
        cd <= d; cv <= 1'b1;
        @(posedge clk);
        cv <= 1'b0;
        @(posedge clk);
        chk("word_valid", 32'h1, {31'h0, wv});
        chk("word", {12'h0, expw(f, d)}, {12'h0, word});
        @(posedge clk);
        chk("word_valid end", 32'h0, {31'h0, wv});
    endtask
    // =====================================================
    // scenarios
    task t_reset;
        wb(1'b0, `OWF_ADDR_FORMAT, 32'h0);
        chk("format reset", 32'h0, rdat);
        conv(8'h00, 18'h2d1e7);
        $display("done reset");
    endtask
    task t_reserved;
        wb(1'b1, `OWF_ADDR_FORMAT, 32'h000000ff);
        wb(1'b0, `OWF_ADDR_FORMAT, 32'h0);
        chk("format read", 32'h0000003f, rdat);
        conv(8'h3f, 18'h12345);
        $display("done reserved");
    endtask
    task t_patterns;
        for (int i = 0; i < 8; i++) begin
            fmt = {2'b00, i[1:0], 1'b1, i[2:0]};
            wb(1'b1, `OWF_ADDR_FORMAT, {24'h0, fmt});
            conv(fmt, 18'h2b6c1 ^ {i[3:0], 14'h0});
        end
        $display("done patterns");
    endtask
    task t_noparity;
        wb(1'b1, `OWF_ADDR_FORMAT, 32'h00000036);
        conv(8'h36, 18'h0f0f1);
        $display("done no parity");
    endtask
    task t_unmapped;
        wb(1'b1, 8'h40, 32'h0000000f);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped read", 32'h0, rdat);
        // byte lane 0 off: the write must be dropped
        wsel = 4'he;
        wb(1'b1, `OWF_ADDR_FORMAT, 32'h00000001);
        wsel = 4'hf;
        wb(1'b0, `OWF_ADDR_FORMAT, 32'h0);
        chk("format kept", 32'h00000036, rdat);
        chk("host count", 32'h0000000b, {16'h0, hcount});
        chk("host word", {12'h0, expw(8'h36, 18'h0f0f1)}, {12'h0, hlast});
        wb(1'b0, `OWF_ADDR_STATUS, 32'h0);
        chk("status", {12'h0, expw(8'h36, 18'h0f0f1)}, rdat);
        $display("done unmapped");
    endtask
    // =====================================================
    // run
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clk = 1'b0; rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
        sel = 4'hf; dat = 32'h0; cd = 18'h00000; cv = 1'b0; fmt = 8'h00;
        wsel = 4'hf;
        bad_count = 0; tests_run = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_reserved;
        t_patterns;
        t_noparity;
        t_unmapped;
        close_out;
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        close_out;
    end
endmodule
